// ---- design/prox_regs_pkg.sv ----
// Purpose: Shared constants and types for the proximity sensor control register bank
// Assumes: Byte-wide register port from the serial slave engine
// Notes: Identity part number value is arbitrary
package prox_regs_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h00;
  localparam logic [7:0] ADDR_SOFT_RESTART = 8'h01;
  localparam logic [7:0] ADDR_IRQ_PIN_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_LED_PULSE_DIVIDER = 8'h0d;
  localparam logic [7:0] ADDR_RECEIVER_SAMPLE_LAG = 8'h0e;
  localparam logic [7:0] ADDR_LED_DRIVE_STRENGTH = 8'h0f;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;

  // Field positions
  localparam int SOFT_RESTART_BIT = 0;
  localparam int IRQ_EDGE_BIT = 2;
  localparam int IRQ_AUTO_BIT = 1;
  localparam int IRQ_POL_BIT = 0;

  // Reset values
  localparam logic [2:0] IRQ_CFG_RESET = 3'h2;
  localparam logic [4:0] LED_DIV_RESET = 5'h10;
  localparam logic [4:0] SAMPLE_LAG_RESET = 5'h05;
  localparam logic [4:0] LED_SINK_RESET = 5'h09;

  // Identity: part number value is arbitrary
  localparam logic [3:0] PART_NUMBER_DEFAULT = 4'h3;
  localparam logic [3:0] REVISION_DEFAULT = 4'h1;

  // Timing: one tick of the 4 MHz reference is 250 ns; sample lag step 125 ns
  localparam int SYS_PERIOD_PS = 4000;
  localparam int REF_PERIOD_PS = 250000;
  localparam int LAG_STEP_PS = 125000;
  localparam int REF_TICK_CYCLES = REF_PERIOD_PS / SYS_PERIOD_PS;
  localparam int LAG_STEP_CYCLES = LAG_STEP_PS / SYS_PERIOD_PS;
  localparam logic [4:0] LAG_NONE_MAX = 5'h01;
  localparam logic [4:0] LED_SINK_OFF = 5'h00;

  // Configuration carried to the analogue front end
  typedef struct packed {
    logic edge_mode;
    logic auto_update;
    logic active_high;
  } irq_cfg_t;

  // Byte access from the serial slave engine
  typedef struct packed {
    logic start;
    logic wr;
    logic rd;
    logic stop;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : prox_regs_pkg

// ---- design/prox_sensor_ctrl_regs.sv ----
// Purpose: Control register bank for the proximity sensor: identity, soft restart,
//          interrupt pin shaping, LED pulse divider, sample lag and LED sink code
// Assumes: The serial slave engine presents byte requests, one-cycle strobes
// Notes: The 4 MHz reference is derived from sys_clk_i by a tick counter
// What this block does
// R1 - Identity reads part and revision, ignores writes
// R2 - Restart bit plus stop restores all defaults
// R3 - Edge bit clear: pin follows status level
// R4 - Edge bit set: pulse per measurement while set
// R5 - Auto bit clear: latch until status read
// R6 - Auto bit set: re-evaluate each measurement
// R7 - Polarity bit zero low, one high
// R8 - LED rate is reference over divider
// R9 - Host keeps divider within two to 31
// R10 - Sample lag zero for 0/1, else (N-1)x125ns
// R11 - Host keeps lag code within divider
// R12 - Sink current 5 mA plus code x 5
// R13 - Sink code zero turns driver off
// R14 - Multi-byte write advances register pointer
// R15 - Defaults load at power-up and restart
// R16 - Don't care bits ignored, read zero
// R17 - Restart bit self-clears with reset
`timescale 1ns/1ps
`default_nettype none

module prox_sensor_ctrl_regs
  import prox_regs_pkg::*;
#(
  parameter logic [3:0] PART_NUMBER = PART_NUMBER_DEFAULT,
  parameter logic [3:0] REVISION = REVISION_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire reg_req_t req_i,
  output logic [7:0] rdata_o,
  input wire logic meas_done_i,
  input wire logic meas_hit_i,
  output logic irq_pin_o,
  output logic irq_status_o,
  output logic led_pulse_o,
  output logic rx_sample_o,
  output logic led_driver_en_o,
  output logic [4:0] led_sink_code_o,
  output irq_cfg_t irq_cfg_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic restart_armed;
  logic next_restart_armed;
  irq_cfg_t cfg;
  irq_cfg_t next_cfg;
  logic [4:0] led_div;
  logic [4:0] next_led_div;
  logic [4:0] lag_code;
  logic [4:0] next_lag_code;
  logic [4:0] sink_code;
  logic [4:0] next_sink_code;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic do_restart;
  logic [7:0] acc_addr;

  // Restart fires when an armed restart bit meets the stop
  assign do_restart = restart_armed & req_i.stop; // R2

  // Address of the byte in flight: pointer auto-increments after each byte
  assign acc_addr = req_i.start ? req_i.addr : ptr;

  // Next register values from bus writes
  always_comb begin
    next_ptr = ptr;
    next_restart_armed = restart_armed;
    next_cfg = cfg;
    next_led_div = led_div;
    next_lag_code = lag_code;
    next_sink_code = sink_code;
    if (req_i.wr || req_i.rd) begin
      next_ptr = acc_addr + 8'h01; // R14
    end else if (req_i.start) begin
      next_ptr = req_i.addr;
    end
    if (req_i.wr) begin
      if (acc_addr == ADDR_SOFT_RESTART) begin
        next_restart_armed = req_i.wdata[SOFT_RESTART_BIT]; // R16
      end else if (acc_addr == ADDR_IRQ_PIN_CONFIG) begin
        next_cfg.edge_mode = req_i.wdata[IRQ_EDGE_BIT];
        next_cfg.auto_update = req_i.wdata[IRQ_AUTO_BIT];
        next_cfg.active_high = req_i.wdata[IRQ_POL_BIT];
      end else if (acc_addr == ADDR_LED_PULSE_DIVIDER) begin
        next_led_div = req_i.wdata[4:0]; // R16
      end else if (acc_addr == ADDR_RECEIVER_SAMPLE_LAG) begin
        next_lag_code = req_i.wdata[4:0];
      end else if (acc_addr == ADDR_LED_DRIVE_STRENGTH) begin
        next_sink_code = req_i.wdata[4:0];
      end
    end
  end

  // Register update; restart and power-on both load defaults
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || do_restart) begin // R15
      ptr <= 8'h00;
      restart_armed <= 1'b0; // R17
      cfg <= irq_cfg_t'(IRQ_CFG_RESET);
      led_div <= LED_DIV_RESET;
      lag_code <= SAMPLE_LAG_RESET;
      sink_code <= LED_SINK_RESET;
    end else begin
      ptr <= next_ptr;
      restart_armed <= next_restart_armed;
      cfg <= next_cfg;
      led_div <= next_led_div;
      lag_code <= next_lag_code;
      sink_code <= next_sink_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and pin
  logic status;
  logic next_status;
  logic pulse;
  logic next_pulse;
  logic status_read;

  assign status_read = req_i.rd && (acc_addr == ADDR_IRQ_STATUS);

  // Status: latched or re-evaluated per measurement; a hit beats a read clear
  always_comb begin
    next_status = status;
    next_pulse = 1'b0;
    if (cfg.auto_update) begin
      if (meas_done_i) begin
        next_status = meas_hit_i; // R6
      end
    end else begin
      if (meas_done_i && meas_hit_i) begin
        next_status = 1'b1; // R5
      end else if (status_read) begin
        next_status = 1'b0; // R5
      end
    end
    if (cfg.edge_mode && meas_done_i) begin
      next_pulse = next_status; // R4
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || do_restart) begin
      status <= 1'b0;
      pulse <= 1'b0;
    end else begin
      status <= next_status;
      pulse <= next_pulse;
    end
  end

  // Pin: level or pulse, then polarity
  logic irq_active;
  assign irq_active = cfg.edge_mode ? pulse : status; // R3
  assign irq_pin_o = cfg.active_high ? irq_active : ~irq_active; // R7

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered
  always_comb begin
    next_rdata = rdata;
    if (req_i.rd) begin
      if (acc_addr == ADDR_DEVICE_IDENTITY) begin
        next_rdata = {PART_NUMBER, REVISION}; // R1
      end else if (acc_addr == ADDR_SOFT_RESTART) begin
        next_rdata = {7'h00, restart_armed}; // R16
      end else if (acc_addr == ADDR_IRQ_PIN_CONFIG) begin
        next_rdata = {5'h00, cfg.edge_mode, cfg.auto_update, cfg.active_high};
      end else if (acc_addr == ADDR_LED_PULSE_DIVIDER) begin
        next_rdata = {3'h0, led_div};
      end else if (acc_addr == ADDR_RECEIVER_SAMPLE_LAG) begin
        next_rdata = {3'h0, lag_code};
      end else if (acc_addr == ADDR_LED_DRIVE_STRENGTH) begin
        next_rdata = {3'h0, sink_code};
      end else if (acc_addr == ADDR_IRQ_STATUS) begin
        next_rdata = {7'h00, status};
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LED pulse generator from the 4 MHz reference tick
  localparam logic [5:0] REF_TICK_LAST = 6'(REF_TICK_CYCLES - 1);
  localparam logic [4:0] LAG_STEP_LAST = 5'(LAG_STEP_CYCLES - 1);
  logic [5:0] ref_cnt;
  logic [5:0] next_ref_cnt;
  logic [4:0] div_cnt;
  logic [4:0] next_div_cnt;
  logic led;
  logic next_led;
  logic [4:0] lag_left;
  logic [4:0] next_lag_left;
  logic [4:0] step_cnt;
  logic [4:0] next_step_cnt;
  logic lag_busy;
  logic next_lag_busy;
  logic sample;
  logic next_sample;
  logic ref_tick;
  logic led_edge;

  assign ref_tick = (ref_cnt == REF_TICK_LAST);

  // Divider: period of led_div ticks, high for the first half
  always_comb begin
    next_ref_cnt = ref_tick ? 6'h00 : ref_cnt + 6'h01;
    next_div_cnt = div_cnt;
    next_led = led;
    led_edge = 1'b0;
    if (ref_tick) begin
      if (div_cnt >= led_div - 5'h01) begin // R8
        next_div_cnt = 5'h00;
      end else begin
        next_div_cnt = div_cnt + 5'h01;
      end
      next_led = (next_div_cnt < {1'b0, led_div[4:1]});
      led_edge = (next_led != led);
    end
  end

  // Sample lag: (N-1) steps of 125 ns after each LED edge
  always_comb begin
    next_lag_left = lag_left;
    next_step_cnt = step_cnt;
    next_lag_busy = lag_busy;
    next_sample = 1'b0;
    if (led_edge) begin
      if (lag_code <= LAG_NONE_MAX) begin
        next_sample = 1'b1; // R10
        next_lag_busy = 1'b0;
      end else begin
        next_lag_left = lag_code - 5'h01; // R10
        next_step_cnt = 5'h00;
        next_lag_busy = 1'b1;
      end
    end else if (lag_busy) begin
      if (step_cnt == LAG_STEP_LAST) begin
        next_step_cnt = 5'h00;
        next_lag_left = lag_left - 5'h01;
        if (lag_left == 5'h01) begin
          next_sample = 1'b1;
          next_lag_busy = 1'b0;
        end
      end else begin
        next_step_cnt = step_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || do_restart) begin
      ref_cnt <= 6'h00;
      div_cnt <= 5'h00;
      led <= 1'b0;
      lag_left <= 5'h00;
      step_cnt <= 5'h00;
      lag_busy <= 1'b0;
      sample <= 1'b0;
    end else begin
      ref_cnt <= next_ref_cnt;
      div_cnt <= next_div_cnt;
      led <= next_led;
      lag_left <= next_lag_left;
      step_cnt <= next_step_cnt;
      lag_busy <= next_lag_busy;
      sample <= next_sample;
    end
  end

  // Outputs; sink current is 5 mA plus code times 5 mA in the analogue driver
  assign led_pulse_o = led & (sink_code != LED_SINK_OFF); // R13
  assign led_driver_en_o = (sink_code != LED_SINK_OFF); // R13
  assign led_sink_code_o = sink_code; // R12
  assign rx_sample_o = sample;
  assign rdata_o = rdata;
  assign irq_status_o = status;
  assign irq_cfg_o = cfg;

endmodule : prox_sensor_ctrl_regs

`default_nettype wire

// ---- tb/i2c_host_model.sv ----
// Purpose: Host model issuing byte requests to the bank
// Assumes: Requests change only at rising edges
// Notes: Field order is start, wr, rd, stop
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
  import prox_regs_pkg::*;
(
  input wire logic clk_i,
  output var reg_req_t req_o
);
  ////////////////////////////////////////
  // Quiet until the bench asks
  initial req_o = '0;
  // One request cycle; the next call or an idle call ends it
  task automatic put(input logic [3:0] f, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= {f, a, d};
  endtask : put
endmodule : i2c_host_model
`default_nettype wire

// ---- tb/prox_sensor_ctrl_regs_props.sv ----
// Purpose: Port checks for the control register bank
// Assumes: One clock, synchronous reset
// Notes: Bound to every bank instance
`timescale 1ns/1ps
`default_nettype none
module prox_regs_checker
  import prox_regs_pkg::*;
#(
  parameter logic [3:0] PART_NUMBER = 4'h0,
  parameter logic [3:0] REVISION = 4'h0
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire reg_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic meas_done_i,
  input wire logic meas_hit_i,
  input wire logic irq_pin_o,
  input wire logic irq_status_o,
  input wire logic led_pulse_o,
  input wire logic rx_sample_o,
  input wire logic led_driver_en_o,
  input wire logic [4:0] led_sink_code_o,
  input wire irq_cfg_t irq_cfg_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  // Interrupt pin shaping
  chk_level_pin: assert property (!irq_cfg_o.edge_mode |->
    irq_pin_o == ~(irq_status_o ^ irq_cfg_o.active_high)) else $error("level pin");
  chk_edge_quiet: assert property (irq_cfg_o.edge_mode && !$past(meas_done_i) |->
    irq_pin_o == !irq_cfg_o.active_high) else $error("edge idle");
  chk_edge_pulse: assert property (irq_cfg_o.edge_mode && $past(meas_done_i) && irq_status_o |->
    irq_pin_o == irq_cfg_o.active_high) else $error("edge pulse");
  // Status update and latching
  chk_auto_eval: assert property (irq_cfg_o.auto_update && meas_done_i && !req_i.stop |=>
    irq_status_o == $past(meas_hit_i)) else $error("auto status");
  chk_latch_set: assert property (!irq_cfg_o.auto_update && meas_done_i && meas_hit_i |=>
    irq_status_o) else $error("latch set");
  chk_latch_hold: assert property (!irq_cfg_o.auto_update && irq_status_o && !req_i.rd && !req_i.stop |=>
    irq_status_o) else $error("latch hold");
  // LED driver
  chk_drv_enable: assert property (led_driver_en_o == (led_sink_code_o != 5'h00))
    else $error("driver enable");
  chk_led_gated: assert property (!led_driver_en_o |-> !led_pulse_o)
    else $error("led gated");
  // A stop may restart the bank and drop the LED early, so it ends the attempt
  chk_led_hold: assert property (disable iff (srst_i || req_i.stop)
    $rose(led_pulse_o) && $past(led_driver_en_o) |=> (led_pulse_o || !led_driver_en_o) [*8])
    else $error("led high");
  // Reads and sampling
  chk_ident_read: assert property (req_i.rd && req_i.start && req_i.addr == 8'h00 |=>
    rdata_o == {PART_NUMBER, REVISION}) else $error("identity");
  chk_rx_single: assert property (rx_sample_o |=> !rx_sample_o)
    else $error("sample width");
  cov_edge: cover property (irq_cfg_o.edge_mode && irq_status_o && $past(meas_done_i));
  cov_latch: cover property (!irq_cfg_o.auto_update && irq_status_o);
  cov_sample: cover property (rx_sample_o);
endmodule : prox_regs_checker
bind prox_sensor_ctrl_regs prox_regs_checker #(.PART_NUMBER(PART_NUMBER), .REVISION(REVISION)) chk (
  .sys_clk_i(sys_clk_i),
  .srst_i(srst_i),
  .req_i(req_i),
  .rdata_o(rdata_o),
  .meas_done_i(meas_done_i),
  .meas_hit_i(meas_hit_i),
  .irq_pin_o(irq_pin_o),
  .irq_status_o(irq_status_o),
  .led_pulse_o(led_pulse_o),
  .rx_sample_o(rx_sample_o),
  .led_driver_en_o(led_driver_en_o),
  .led_sink_code_o(led_sink_code_o),
  .irq_cfg_o(irq_cfg_o)
);
`default_nettype wire

// ---- tb/test_prox_sensor_ctrl_regs.sv ----
// Purpose: Bench for the control register bank
// Assumes: Host model drives the byte port
// Notes: Register results are compared at the falling edge; t_period timings are taken at the LED and sample edges
`timescale 1ns/1ps
`default_nettype none
module test_prox_sensor_ctrl_regs
  import prox_regs_pkg::*;
;
  logic sys_clk_i, srst_i, meas_done_i, meas_hit_i;
  logic irq_pin_o, irq_status_o, led_pulse_o, rx_sample_o, led_driver_en_o;
  logic [7:0] rdata_o;
  logic [4:0] led_sink_code_o;
  irq_cfg_t irq_cfg_o;
  reg_req_t req_i;
  int err_total = 0;
  int checked = 0;
  localparam logic [7:0] IDENT = {PART_NUMBER_DEFAULT, REVISION_DEFAULT};
  i2c_host_model host (.clk_i(sys_clk_i), .req_o(req_i));
  prox_sensor_ctrl_regs dut (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .req_i(req_i),
    .rdata_o(rdata_o),
    .meas_done_i(meas_done_i),
    .meas_hit_i(meas_hit_i),
    .irq_pin_o(irq_pin_o),
    .irq_status_o(irq_status_o),
    .led_pulse_o(led_pulse_o),
    .rx_sample_o(rx_sample_o),
    .led_driver_en_o(led_driver_en_o),
    .led_sink_code_o(led_sink_code_o),
    .irq_cfg_o(irq_cfg_o)
  );
  ////////////////////////////////////////
  // Clock and run limit
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #50000;
    err_total++;
    complete_run();
  end
  // Shared helpers
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic wr(input logic st, input logic [7:0] a, input logic [7:0] d);
    host.put({st, 3'b100}, a, d);
  endtask : wr
  // Ends a held request so it is taken exactly once
  task automatic idle;
    host.put(4'h0, 8'h00, 8'h00);
  endtask : idle
  task automatic rd(input logic st, input logic [7:0] a, input logic [7:0] e);
    host.put({st, 3'b010}, a, 8'h00);
    host.put(4'h0, 8'h00, 8'h00);
    @(negedge sys_clk_i);
    cmp("rdata", {8'h00, e}, {8'h00, rdata_o});
  endtask : rd
  task automatic meas(input logic h);
    @(posedge sys_clk_i);
    meas_done_i <= 1'b1;
    meas_hit_i <= h;
    @(posedge sys_clk_i);
    meas_done_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask : meas
  // Scenarios
  task automatic t_defaults;
    rd(1'b1, 8'h00, IDENT);
    rd(1'b0, 8'h00, 8'h00);
    rd(1'b0, 8'h00, {5'h00, IRQ_CFG_RESET});
    rd(1'b1, 8'h0d, {3'h0, LED_DIV_RESET});
    rd(1'b0, 8'h00, {3'h0, SAMPLE_LAG_RESET});
    rd(1'b0, 8'h00, {3'h0, LED_SINK_RESET});
    cmp("pin", 16'h0001, {15'h0, irq_pin_o});
  endtask : t_defaults
  task automatic t_burst;
    wr(1'b1, 8'h0d, 8'he8);
    wr(1'b0, 8'h00, 8'he3);
    wr(1'b0, 8'h00, 8'he0);
    wr(1'b1, 8'h00, 8'hff);
    rd(1'b1, 8'h0d, 8'h08);
    rd(1'b0, 8'h00, 8'h03);
    rd(1'b0, 8'h00, 8'h00);
    cmp("drv", 16'h0000, {15'h0, led_driver_en_o});
    rd(1'b1, 8'h00, IDENT);
    wr(1'b1, 8'h0f, 8'h01);
    host.put(4'h0, 8'h00, 8'h00);
    @(negedge sys_clk_i);
    cmp("sink", 16'h0001, {11'h0, led_sink_code_o});
  endtask : t_burst
  task automatic t_period;
    time t0;
    // First rise may be cut short by the driver turning on; measure the next one
    @(posedge led_pulse_o);
    @(posedge led_pulse_o);
    t0 = $time;
    @(posedge rx_sample_o);
    cmp("lag", 16'(2 * LAG_STEP_CYCLES), 16'(($time - t0) / 4));
    @(negedge led_pulse_o);
    cmp("high", 16'(4 * REF_TICK_CYCLES), 16'(($time - t0) / 4));
    @(posedge led_pulse_o);
    cmp("period", 16'(8 * REF_TICK_CYCLES), 16'(($time - t0) / 4));
    wr(1'b1, 8'h0e, 8'h01);
    idle();
    @(posedge led_pulse_o);
    @(negedge sys_clk_i);
    cmp("nolag", 16'h0001, {15'h0, rx_sample_o});
  endtask : t_period
  task automatic t_irq;
    wr(1'b1, 8'h02, 8'hf9);
    rd(1'b1, 8'h02, 8'h01);
    cmp("cfg", 16'h0001, {13'h0, irq_cfg_o});
    meas(1'b1);
    cmp("pin", 16'h0001, {15'h0, irq_pin_o});
    meas(1'b0);
    cmp("hold", 16'h0001, {15'h0, irq_status_o});
    rd(1'b1, 8'h40, 8'h01);
    cmp("clear", 16'h0000, {15'h0, irq_status_o});
    wr(1'b1, 8'h02, 8'h04);
    idle();
    meas(1'b1);
    cmp("pulse", 16'h0000, {15'h0, irq_pin_o});
    @(negedge sys_clk_i);
    cmp("edge", 16'h0001, {15'h0, irq_pin_o});
    wr(1'b1, 8'h02, 8'h02);
    idle();
    meas(1'b0);
    cmp("auto", 16'h0000, {15'h0, irq_status_o});
  endtask : t_irq
  task automatic t_restart;
    wr(1'b1, 8'h0f, 8'h1f);
    wr(1'b1, 8'h01, 8'h01);
    rd(1'b1, 8'h01, 8'h01);
    cmp("armed", 16'h001f, {11'h0, led_sink_code_o});
    host.put(4'h1, 8'h00, 8'h00);
    rd(1'b1, 8'h01, 8'h00);
    rd(1'b0, 8'h00, {5'h00, IRQ_CFG_RESET});
    rd(1'b1, 8'h0f, {3'h0, LED_SINK_RESET});
  endtask : t_restart
  // Verdict
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    meas_done_i = 1'b0;
    meas_hit_i = 1'b0;
    srst_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_defaults();
    t_burst();
    t_period();
    t_irq();
    t_restart();
    complete_run();
  end
endmodule : test_prox_sensor_ctrl_regs
`default_nettype wire
